// ---- logic/jump_barrier_map.vh ----
`ifndef JUMP_BARRIER_MAP_VH
`define JUMP_BARRIER_MAP_VH

// instruction fields
`define OP_MSB 31
`define OP_LSB 26
`define TREG_MSB 25
`define TREG_LSB 21
`define ZERO_MSB 20
`define ZERO_LSB 16
`define LREG_MSB 15
`define LREG_LSB 11
`define BARRIER_BIT 10
`define FUNCT_MSB 5
`define FUNCT_LSB 0
`define INDEX_MSB 25
`define INDEX_LSB 0

// encodings
`define OPC_SPECIAL 6'h00
`define OPC_REGION_CALL 6'h1D
`define FUNCT_LINK_JUMP 6'h09
`define RETURN_REG 5'h1F
`define LINK_OFFSET 32'h00000008
`define SLOT_OFFSET 32'h00000004
`define REGION_SHIFT 2
`define REGION_BITS 28

// status bits
`define ST_ADDR_ERR 0
`define ST_RESV_INSTR 1
`define ST_BARRIER 2
`define ST_WIDTH 3

// register offsets
`define REG_STATUS 4'h0
`define REG_MASK 4'h4
`define REG_CONFIG 4'h8
`define REG_STATE 4'hC

// reset values
`define MASK_RESET 3'h0
`define CONFIG_RESET 1'h0

`endif

// ---- logic/jump_target_check.v ----
`timescale 1ns/100ps
`default_nettype none

// fetch-time alignment check of a redirect target
module jump_target_check (
    // target
    input wire [31:0] i_target,
    input wire i_isa_sel,
    // configuration
    input wire i_compressed,
    // result
    output reg o_addr_err
);

always @* begin
    if (i_compressed) begin
        o_addr_err = (i_isa_sel == 1'b0) && i_target[1];
    end else begin
        o_addr_err = |i_target[1:0];
    end
end

endmodule // jump_target_check

`default_nettype wire

// ---- logic/jump_link_hazard_barrier.v ----
// How it works
// - barrier jump: link-jump funct with bit 10
// - link register gets jump address plus 8
// - delay slot runs before the redirect
// - compressed: register target bit 0 cleared, mode loaded
// - hazards cleared before the target fetch
// - barrier jump legal in every mode
// - delay slot hazards are not covered
// - plain core: low two bits fault
// - compressed: bit0 zero, bit1 one faults
// - region call: index shifted into region
// - region call links r31 with mode bit
// - region call toggles the mode
// - region call targets word aligned only
// - region call reserved without compressed set
`timescale 1ns/100ps
`default_nettype none
`include "jump_barrier_map.vh"

module jump_link_hazard_barrier (
    // clock and reset
    input wire i_clk,
    input wire i_nrst,
    // instruction stream
    input wire i_instr_valid,
    input wire [31:0] i_instr,
    input wire [31:0] i_pc,
    // register file read
    output wire [4:0] o_rd_addr,
    input wire [31:0] i_rd_data,
    // register file write
    output reg o_wr_en,
    output reg [4:0] o_wr_addr,
    output reg [31:0] o_wr_data,
    // fetch redirect
    output reg o_redirect,
    output reg [31:0] o_redirect_pc,
    output reg o_isa_sel,
    output reg o_addr_err,
    output reg o_resv_instr,
    // hazard barrier
    output reg o_clear_hazards,
    output wire o_slot_pending,
    // software port
    input wire [3:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    output wire o_irq
);

// ---------------------------------------------------------------
// decode
// ---------------------------------------------------------------
function is_link_jump;
    input [31:0] ins;
    begin
        is_link_jump = (ins[`OP_MSB:`OP_LSB] == `OPC_SPECIAL) &&
            (ins[`FUNCT_MSB:`FUNCT_LSB] == `FUNCT_LINK_JUMP);
    end
endfunction

function is_region_call;
    input [31:0] ins;
    begin
        is_region_call = (ins[`OP_MSB:`OP_LSB] == `OPC_REGION_CALL);
    end
endfunction

// register offset match, shared by the read and write decoders
function reg_hit;
    input [3:0] addr;
    input [3:0] offset;
    begin
        reg_hit = (addr == offset);
    end
endfunction

wire link_jump = i_instr_valid && is_link_jump(i_instr);
// no privilege check: legal in every mode
wire barrier_jump = link_jump && i_instr[`BARRIER_BIT];
wire region_call = i_instr_valid && is_region_call(i_instr);

reg compressed_isa_present_reg;
reg isa_reg;

assign o_rd_addr = i_instr[`TREG_MSB:`TREG_LSB];

// ---------------------------------------------------------------
// delay slot state
// ---------------------------------------------------------------
localparam ST_IDLE = 1'b0;
localparam ST_SLOT = 1'b1;
reg state_reg;
reg state_next;
wire slot_reg = (state_reg == ST_SLOT);
reg [31:0] tgt_reg;
reg tgt_isa_reg;
reg barrier_reg;
reg [31:0] slot_pc_reg;

wire slot_done = slot_reg && i_instr_valid;
assign o_slot_pending = slot_reg;

// register jump target: bit 0 selects the mode when compressed code exists
function [32:0] reg_jump;
    input [31:0] value;
    input compressed;
    input mode;
    begin
        if (compressed) begin
            reg_jump = {value[0], value[31:1], 1'b0};
        end else begin
            reg_jump = {mode, value};
        end
    end
endfunction

wire [32:0] reg_jump_word = reg_jump(i_rd_data, compressed_isa_present_reg,
    isa_reg);
wire [31:0] reg_target = reg_jump_word[31:0];
wire reg_isa = reg_jump_word[32];

// region call target: upper bits from the delay slot address
wire [31:0] slot_addr = i_pc + `SLOT_OFFSET;
wire [31:0] region_target = {slot_addr[31:`REGION_BITS],
    i_instr[`INDEX_MSB:`INDEX_LSB], 2'b00};

// return links: second instruction after the jump
wire [31:0] plain_link = i_pc + `LINK_OFFSET;
wire [31:0] region_link = {plain_link[31:1], isa_reg};

wire chk_err;

jump_target_check u_check (
    .i_target(tgt_reg),
    .i_isa_sel(tgt_isa_reg),
    .i_compressed(compressed_isa_present_reg),
    .o_addr_err(chk_err)
);

wire resv = region_call && !compressed_isa_present_reg;

// ---------------------------------------------------------------
// jump capture: target and mode held for the slot
// ---------------------------------------------------------------
wire take_link = !slot_reg && link_jump;
wire take_region = !slot_reg && !resv && region_call;

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        tgt_reg <= 32'h00000000;
        tgt_isa_reg <= 1'b0;
        barrier_reg <= 1'b0;
        slot_pc_reg <= 32'h00000000;
    end else if (take_link) begin
        tgt_reg <= reg_target;
        tgt_isa_reg <= reg_isa;
        // latched at the jump, so slot hazards stay outside
        barrier_reg <= barrier_jump;
        slot_pc_reg <= slot_addr;
    end else if (take_region) begin
        tgt_reg <= region_target;
        tgt_isa_reg <= ~isa_reg;
        barrier_reg <= 1'b0;
        slot_pc_reg <= slot_addr;
    end
end

// ---------------------------------------------------------------
// delay slot sequencer
// ---------------------------------------------------------------
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE: begin
            if (take_link || take_region) begin
                state_next = ST_SLOT;
            end
        end
        ST_SLOT: begin
            if (i_instr_valid) begin
                state_next = ST_IDLE;
            end
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        state_reg <= ST_IDLE;
    end else begin
        state_reg <= state_next;
    end
end

// ---------------------------------------------------------------
// link write
// ---------------------------------------------------------------
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_wr_en <= 1'b0;
        o_wr_addr <= 5'h00;
        o_wr_data <= 32'h00000000;
    end else begin
        o_wr_en <= take_link || take_region;
        if (take_link) begin
            o_wr_addr <= i_instr[`LREG_MSB:`LREG_LSB];
            o_wr_data <= plain_link;
        end else if (take_region) begin
            o_wr_addr <= `RETURN_REG;
            o_wr_data <= region_link;
        end
    end
end

// ---------------------------------------------------------------
// redirect after the slot instruction
// ---------------------------------------------------------------
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_redirect <= 1'b0;
        o_redirect_pc <= 32'h00000000;
        o_isa_sel <= 1'b0;
        isa_reg <= 1'b0;
        o_addr_err <= 1'b0;
        o_clear_hazards <= 1'b0;
    end else begin
        o_redirect <= slot_done;
        o_addr_err <= slot_done && chk_err;
        o_clear_hazards <= slot_done && barrier_reg;
        if (slot_done) begin
            o_redirect_pc <= tgt_reg;
            o_isa_sel <= tgt_isa_reg;
            isa_reg <= tgt_isa_reg;
        end
    end
end

// ---------------------------------------------------------------
// reserved instruction
// ---------------------------------------------------------------
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_resv_instr <= 1'b0;
    end else begin
        o_resv_instr <= !slot_reg && resv;
    end
end

// ---------------------------------------------------------------
// status, mask and configuration
// ---------------------------------------------------------------
reg [`ST_WIDTH-1:0] status_reg;
reg [`ST_WIDTH-1:0] mask_reg;
wire [`ST_WIDTH-1:0] events = {o_clear_hazards, o_resv_instr, o_addr_err};
wire rd_status = i_rd && reg_hit(i_addr, `REG_STATUS);
wire wr_mask = i_wr && reg_hit(i_addr, `REG_MASK);
wire wr_config = i_wr && reg_hit(i_addr, `REG_CONFIG);
wire [`ST_WIDTH-1:0] status_next;

// per bit: a new event wins over the clear by read
genvar gi;
generate
    for (gi = 0; gi < `ST_WIDTH; gi = gi + 1) begin : g_status
        assign status_next[gi] = events[gi] | (status_reg[gi] & ~rd_status);
    end
endgenerate

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        status_reg <= {`ST_WIDTH{1'b0}};
    end else begin
        status_reg <= status_next;
    end
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        mask_reg <= `MASK_RESET;
    end else if (wr_mask) begin
        mask_reg <= i_wdata[`ST_WIDTH-1:0];
    end
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        compressed_isa_present_reg <= `CONFIG_RESET;
    end else if (wr_config) begin
        compressed_isa_present_reg <= i_wdata[0];
    end
end

// ---------------------------------------------------------------
// read data
// ---------------------------------------------------------------
function [31:0] read_word;
    input [3:0] addr;
    input [`ST_WIDTH-1:0] status;
    input [`ST_WIDTH-1:0] mask;
    input config_bit;
    input mode_bit;
    input pending_bit;
    begin
        case (addr)
            `REG_STATUS: read_word = {29'h00000000, status};
            `REG_MASK: read_word = {29'h00000000, mask};
            `REG_CONFIG: read_word = {31'h00000000, config_bit};
            `REG_STATE: read_word = {30'h00000000, mode_bit, pending_bit};
            default: read_word = 32'h00000000;
        endcase
    end
endfunction

wire [31:0] rd_word = read_word(i_addr, status_reg, mask_reg,
    compressed_isa_present_reg, isa_reg, slot_reg);

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_rdata <= 32'h00000000;
    end else begin
        o_rdata <= i_rd ? rd_word : 32'h00000000;
    end
end

// ---------------------------------------------------------------
// interrupt
// ---------------------------------------------------------------
assign o_irq = |(status_reg & mask_reg);

endmodule // jump_link_hazard_barrier

`default_nettype wire

// ---- tb/regfile_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ------
// register file: each value carries its own index in its low bits
// ------
module regfile_model (
    // read port
    input wire logic [4:0] i_addr,
    output logic [31:0] o_data
);
    assign o_data = {27'h0000100, i_addr};
endmodule // regfile_model
`default_nettype wire

// ---- tb/jump_barrier_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module jump_barrier_props (
    // watched ports
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_instr_valid,
    input wire logic [31:0] i_instr,
    input wire logic [31:0] i_pc,
    input wire logic o_wr_en,
    input wire logic [4:0] o_wr_addr,
    input wire logic [31:0] o_wr_data,
    input wire logic o_redirect,
    input wire logic [31:0] o_redirect_pc,
    input wire logic o_isa_sel,
    input wire logic o_addr_err,
    input wire logic o_resv_instr,
    input wire logic o_clear_hazards,
    input wire logic o_slot_pending
);
    // ------
    // jump decode and its effects
    // ------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire lj = i_instr_valid && !o_slot_pending && i_instr[31:26] == 6'h00 && i_instr[5:0] == 6'h09;
    wire rc = i_instr_valid && !o_slot_pending && i_instr[31:26] == 6'h1D;
    property p_link; lj |=> o_wr_en && o_wr_addr == $past(i_instr[15:11])
        && o_wr_data == $past(i_pc) + 32'h8; endproperty
    a_link: assert property (p_link) else $error("link write wrong");
    property p_pend; lj |=> o_slot_pending; endproperty
    a_pend: assert property (p_pend) else $error("slot not pending");
    property p_slot; o_redirect |-> $past(o_slot_pending) && $past(i_instr_valid); endproperty
    a_slot: assert property (p_slot) else $error("redirect without slot");
    property p_hb; lj && i_instr[10] ##1 i_instr_valid |=> o_redirect && o_clear_hazards; endproperty
    a_hb: assert property (p_hb) else $error("barrier not applied");
    property p_clr; o_clear_hazards |-> o_redirect; endproperty
    a_clr: assert property (p_clr) else $error("clear off redirect");
    property p_err; o_addr_err |-> o_redirect; endproperty
    a_err: assert property (p_err) else $error("error off redirect");
    property p_rtgt; rc ##1 (i_instr_valid && !o_resv_instr) |=> o_redirect
        && o_redirect_pc[27:0] == {$past(i_instr[25:0], 2), 2'h0}; endproperty
    a_rtgt: assert property (p_rtgt) else $error("region target wrong");
    property p_isa; rc ##1 (i_instr_valid && !o_resv_instr) |=> o_isa_sel != $past(o_isa_sel, 2);
    endproperty
    a_isa: assert property (p_isa) else $error("mode not toggled");
    property p_rlink; rc ##1 !o_resv_instr |-> o_wr_en && o_wr_addr == 5'h1F
        && o_wr_data[0] == $past(o_isa_sel); endproperty
    a_rlink: assert property (p_rlink) else $error("region link wrong");
    c_hb: cover property (lj ##1 i_instr_valid ##1 o_clear_hazards);
    c_err: cover property (o_addr_err);
    c_resv: cover property (o_resv_instr);
endmodule // jump_barrier_props
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ------
    // stimulus, expectations and checks
    // ------
    logic i_clk, i_nrst, i_instr_valid, i_wr, i_rd, rd_d, cfg, mode;
    logic [31:0] i_instr, i_pc, i_wdata, i_rd_data, o_wr_data, o_redirect_pc, o_rdata, pc, t, a;
    logic [3:0] i_addr;
    logic [4:0] o_rd_addr, o_wr_addr;
    logic o_wr_en, o_redirect, o_isa_sel, o_addr_err, o_resv_instr, o_clear_hazards;
    logic o_slot_pending, o_irq;
    logic [2:0] st;
    logic [31:0] seed = 32'h0000BFC8;
    logic [63:0] wq[$], rq[$], dq[$];
    int error_cnt, comparisons;
    jump_link_hazard_barrier uut (.*);
    regfile_model pm (.i_addr(o_rd_addr), .o_data(i_rd_data));
    initial begin
        i_clk = 0;
        forever #5 i_clk = ~i_clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(string n, logic [63:0] e, logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic ins(logic [31:0] w, logic [31:0] p);
        @(posedge i_clk);
        i_instr_valid <= 1'h1;
        i_instr <= w;
        i_pc <= p;
    endtask
    task automatic bus(logic w, logic [3:0] ad, logic [31:0] d);
        @(posedge i_clk);
        i_instr_valid <= 1'h0;
        i_wr <= w;
        i_rd <= !w;
        i_addr <= ad;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'h0;
        i_rd <= 1'h0;
    endtask
    task automatic hb(logic [4:0] r);
        pc = rnd() & 32'hFFFFFFFC;
        t = {27'h0000100, r};
        wq.push_back({27'h0, r + 5'h10, pc + 32'h8});
        if (cfg) begin
            rq.push_back({29'h0, t[0], !t[0] && t[1], 1'h1, t[31:1], 1'h0});
            mode = t[0];
        end else
            rq.push_back({29'h0, mode, |t[1:0], 1'h1, t});
        st = st | {1'h1, 1'h0, rq[$][33]};
        ins({6'h00, r, 5'h00, r + 5'h10, 1'h1, 4'h0, 6'h09}, pc);
        ins(32'h0, pc + 32'h4);
    endtask
    task automatic region_call();
        pc = rnd() & 32'hFFFFFFFC;
        a = pc + 32'h4;
        t = rnd();
        if (cfg) begin
            wq.push_back({27'h0, 5'h1F, a[31:1] + 31'h2, mode});
            rq.push_back({29'h0, !mode, 2'h0, a[31:28], t[25:0], 2'h0});
            mode = !mode;
        end else
            st[1] = 1'h1;
        ins({6'h1D, t[25:0]}, pc);
        ins(32'h0, a);
    endtask
    always @(negedge i_clk) begin
        rd_d <= i_rd;
        if (o_wr_en && wq.size() > 0)
            chk("link", wq.pop_front(), {27'h0, o_wr_addr, o_wr_data});
        if (o_redirect && rq.size() > 0)
            chk("redirect", rq.pop_front(), {29'h0, o_isa_sel, o_addr_err, o_clear_hazards,
                o_redirect_pc});
        if (rd_d)
            chk("rdata", dq.pop_front(), {32'h0, o_rdata});
    end
    initial begin
        repeat (5000) @(posedge i_clk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        {i_nrst, i_instr_valid, i_wr, i_rd, mode, i_instr, i_pc, i_addr, i_wdata, st} = 0;
        error_cnt = 0;
        comparisons = 0;
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'h1;
        for (int c = 0; c < 2; c++) begin
            cfg = c[0];
            bus(1'h1, 4'h8, {31'h0, cfg});
            dq.push_back({63'h0, cfg});
            bus(1'h0, 4'h8, 32'h0);
            repeat (6) hb(5'(rnd() % 15 + 1));
            region_call();
            bus(1'h1, 4'h4, 32'h7);
            #1 chk("irq", {63'h0, |st}, {63'h0, o_irq});
            dq.push_back({61'h0, 3'h7});
            bus(1'h0, 4'h4, 32'h0);
            dq.push_back({62'h0, mode, 1'h0});
            bus(1'h0, 4'hC, 32'h0);
            dq.push_back({61'h0, st});
            bus(1'h0, 4'h0, 32'h0);
            st = 3'h0;
            dq.push_back(64'h0);
            bus(1'h0, 4'h2, 32'h0);
            #1 chk("irq", 64'h0, {63'h0, o_irq});
        end
        repeat (3) @(posedge i_clk);
        chk("queues", 64'h0, 64'(wq.size() + rq.size() + dq.size()));
        end_of_test();
    end
endmodule // tb_top
bind jump_link_hazard_barrier jump_barrier_props chk (.*);
`default_nettype wire
